// [verilog/uart_rx_pkg.sv]
// Function
// - oversample 16x normal, 8x double speed
// - falling edge starts detection, first low sample one
// - vote start on samples 8-10 or 4-6
// - majority high start is noise, rearm
// - resync bit counter on each valid start
// - sixteen or eight sample states per bit
// - each bit is majority of centre samples
// - recover through first stop bit only
// - low first stop bit sets frame error
// - detect next start right after stop vote
// - complete flag high while buffer unread
// - disable stops, discards and flushes at once
package uart_rx_pkg;

    // register word offsets (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BAUD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;

    // control register layout, low bits of the word
    typedef struct packed {
        logic [1:0] data_len;
        logic parity_en;
        logic double_speed_select;
        logic receiver_enable;
    } ctrl_s;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // one received frame as kept in the buffer
    typedef struct packed {
        logic parity_bit;
        logic frame_error_flag;
        logic [7:0] data;
    } rx_entry_s;
    localparam logic [9:0] ENTRY_RESET = 10'h000;

    // status register layout
    typedef struct packed {
        logic overrun;
        logic parity_bit;
        logic frame_error_flag;
        logic receive_complete_flag;
    } status_s;

    // interrupt status and mask layout
    typedef struct packed {
        logic noise_reject;
        logic frame_error;
        logic frame_done;
    } irq_s;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // baud divider
    localparam int BAUD_W = 12;
    localparam logic [11:0] BAUD_RESET = 12'h000;

    // sampling figures
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] FIRST_VOTE_NORMAL = 5'h08;
    localparam logic [4:0] FIRST_VOTE_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;
    localparam logic [4:0] SAMPLE_FIRST = 5'h01;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] MAX_DATA_BITS = 4'h8;

    // receiver states
    typedef enum logic [2:0] {
        ST_WAIT_HIGH = 3'b000,
        ST_ARMED = 3'b001,
        ST_START = 3'b010,
        ST_DATA = 3'b011,
        ST_STOP = 3'b100
    } rx_state_e;

    // two of three high gives one
    function automatic logic majority3(input logic [2:0] v);
        majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

endpackage

// [verilog/sync_two_stage.sv]
`timescale 1ns/1ps
module sync_two_stage (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    logic meta;
    logic next_meta;
    logic next_sync;

    // idle-high line, so both stages reset high
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
    end

    // first stage feeds only the second
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync;
        end
    end
endmodule

// [verilog/uart_async_rx_recovery.sv]
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module uart_async_rx_recovery (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // serial line
    input wire logic serial_receive_pin_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // interrupt
    output logic irq_out
);
    import uart_rx_pkg::*;

    logic rx_sync;
    ctrl_s ctrl;
    ctrl_s next_ctrl;
    logic [BAUD_W-1:0] baud_divider;
    logic [BAUD_W-1:0] next_baud_divider;
    logic [31:0] next_wb_dat;
    logic next_wb_ack;
    irq_s irq_status;
    irq_s next_irq_status;
    irq_s irq_mask;
    irq_s next_irq_mask;
    logic next_irq;
    logic [BAUD_W-1:0] baud_cnt;
    logic [BAUD_W-1:0] next_baud_cnt;
    logic tick;
    rx_state_e state;
    rx_state_e next_state;
    logic [4:0] sample_cnt;
    logic [4:0] next_sample_cnt;
    logic [2:0] votes;
    logic [2:0] next_votes;
    logic [3:0] bit_idx;
    logic [3:0] next_bit_idx;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic par_bit;
    logic next_par_bit;
    rx_entry_s entry;
    rx_entry_s next_entry;
    logic receive_complete_flag;
    logic next_receive_complete_flag;
    logic overrun;
    logic next_overrun;
    logic [4:0] bit_len;
    logic [4:0] first_vote;
    logic [4:0] last_vote;
    logic [3:0] n_data;
    logic [3:0] n_bits;
    logic vote_bit;
    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic [31:0] baud_word;
    logic [31:0] mask_word;
    logic store;
    logic store_fe;
    logic pop;
    logic ev_noise;
    status_s status;

    // serial input into the clock domain
    sync_two_stage u_sync (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .async_in(serial_receive_pin_in),
        .sync_out(rx_sync)
    );

    // mode dependent sample figures
    always_comb begin
        if (ctrl.double_speed_select) begin
            bit_len = SAMPLES_DOUBLE;
            first_vote = FIRST_VOTE_DOUBLE;
        end else begin
            bit_len = SAMPLES_NORMAL;
            first_vote = FIRST_VOTE_NORMAL;
        end
        last_vote = first_vote + VOTE_SPAN;
        n_data = MIN_DATA_BITS + {2'b00, ctrl.data_len};
        n_bits = n_data + {3'b000, ctrl.parity_en};
        vote_bit = majority3({votes[1:0], rx_sync});
    end

    // bus decode, byte lane mask
    always_comb begin
        bus_req = wb_cyc_in & wb_stb_in;
        bus_wr = bus_req & wb_ack_out & wb_we_in;
        // read pops when taken, matching the data latched then
        bus_rd = bus_req & ~wb_ack_out & ~wb_we_in;
        wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                 {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
        ctrl_word = {27'h000_0000, ctrl};
        baud_word = {20'h0_0000, baud_divider};
        mask_word = {29'h0000_0000, irq_mask};
        pop = bus_rd & (wb_adr_in == REG_DATA);
        status.overrun = overrun;
        status.parity_bit = entry.parity_bit;
        status.frame_error_flag = entry.frame_error_flag;
        status.receive_complete_flag = receive_complete_flag;
    end

    // register writes, read data and ack
    always_comb begin
        next_ctrl = ctrl;
        next_baud_divider = baud_divider;
        next_irq_mask = irq_mask;
        next_wb_ack = bus_req & ~wb_ack_out;
        next_wb_dat = wb_dat_out;
        if (bus_wr && wb_adr_in == REG_CTRL) begin
            next_ctrl = ctrl_s'(5'((ctrl_word & ~wmask)
                                   | (wb_dat_in & wmask)));
        end
        if (bus_wr && wb_adr_in == REG_BAUD) begin
            next_baud_divider = BAUD_W'((baud_word & ~wmask)
                                        | (wb_dat_in & wmask));
        end
        if (bus_wr && wb_adr_in == REG_IRQ_MASK) begin
            next_irq_mask = irq_s'(3'((mask_word & ~wmask)
                                     | (wb_dat_in & wmask)));
        end
        if (bus_req && !wb_ack_out) begin
            case (wb_adr_in)
                REG_CTRL: next_wb_dat = ctrl_word;
                REG_BAUD: next_wb_dat = baud_word;
                REG_STATUS: next_wb_dat = {28'h000_0000, status};
                REG_DATA: next_wb_dat = {24'h00_0000, entry.data};
                REG_IRQ_STATUS: next_wb_dat = {29'h0000_0000, irq_status};
                REG_IRQ_MASK: next_wb_dat = mask_word;
                default: next_wb_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl <= ctrl_s'(CTRL_RESET);
            baud_divider <= BAUD_RESET;
            irq_mask <= irq_s'(IRQ_RESET);
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            baud_divider <= next_baud_divider;
            irq_mask <= next_irq_mask;
            wb_ack_out <= next_wb_ack;
            wb_dat_out <= next_wb_dat;
        end
    end

    // oversampling tick, one every divider plus one clocks
    always_comb begin
        tick = (baud_cnt == BAUD_RESET);
        if (tick || !ctrl.receiver_enable) begin
            next_baud_cnt = baud_divider;
        end else begin
            next_baud_cnt = baud_cnt - 12'h001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            baud_cnt <= BAUD_RESET;
        end else begin
            baud_cnt <= next_baud_cnt;
        end
    end

    // clock and data recovery, advances on tick only
    always_comb begin
        next_state = state;
        next_sample_cnt = sample_cnt;
        next_votes = votes;
        next_bit_idx = bit_idx;
        next_shift = shift;
        next_par_bit = par_bit;
        store = 1'b0;
        store_fe = 1'b0;
        ev_noise = 1'b0;
        if (!ctrl.receiver_enable) begin
            next_state = ST_WAIT_HIGH;
            next_sample_cnt = SAMPLE_FIRST;
        end else if (tick) begin
            next_sample_cnt = sample_cnt + SAMPLE_FIRST;
            if (sample_cnt >= first_vote && sample_cnt <= last_vote) begin
                next_votes = {votes[1:0], rx_sync};
            end
            case (state)
                ST_WAIT_HIGH: begin
                    if (rx_sync) begin
                        next_state = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (!rx_sync) begin
                        next_state = ST_START;
                        next_sample_cnt = SAMPLE_FIRST + SAMPLE_FIRST;
                    end
                end
                ST_START: begin
                    if (sample_cnt == last_vote && vote_bit) begin
                        next_state = ST_WAIT_HIGH;
                        ev_noise = 1'b1;
                    end else if (sample_cnt == bit_len) begin
                        next_state = ST_DATA;
                        next_sample_cnt = SAMPLE_FIRST;
                        next_bit_idx = 4'h0;
                    end
                end
                ST_DATA: begin
                    if (sample_cnt == last_vote) begin
                        if (bit_idx < n_data) begin
                            next_shift = {vote_bit, shift[7:1]};
                        end else begin
                            next_par_bit = vote_bit;
                        end
                    end
                    if (sample_cnt == bit_len) begin
                        next_sample_cnt = SAMPLE_FIRST;
                        next_bit_idx = bit_idx + 4'h1;
                        if (bit_idx + 4'h1 == n_bits) begin
                            next_state = ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (sample_cnt == last_vote) begin
                        store = 1'b1;
                        store_fe = ~vote_bit;
                        // good stop: rearm at once; bad: wait for high
                        if (vote_bit) begin
                            next_state = ST_ARMED;
                        end else begin
                            next_state = ST_WAIT_HIGH;
                        end
                    end
                end
                default: next_state = ST_WAIT_HIGH;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_WAIT_HIGH;
            sample_cnt <= SAMPLE_FIRST;
            votes <= 3'h7;
            bit_idx <= 4'h0;
            shift <= 8'h00;
            par_bit <= 1'b0;
        end else begin
            state <= next_state;
            sample_cnt <= next_sample_cnt;
            votes <= next_votes;
            bit_idx <= next_bit_idx;
            shift <= next_shift;
            par_bit <= next_par_bit;
        end
    end

    // receive buffer, overrun and interrupt status
    always_comb begin
        next_entry = entry;
        next_receive_complete_flag = receive_complete_flag;
        next_overrun = overrun;
        next_irq_status = irq_status;
        if (bus_wr && wb_adr_in == REG_IRQ_STATUS && wb_sel_in[0]) begin
            next_irq_status = irq_s'(irq_status & ~wb_dat_in[2:0]);
        end
        if (!ctrl.receiver_enable) begin
            next_receive_complete_flag = 1'b0;
            next_overrun = 1'b0;
        end else if (store && (!receive_complete_flag || pop)) begin
            next_entry.data = shift >> (MAX_DATA_BITS - n_data);
            next_entry.frame_error_flag = store_fe;
            next_entry.parity_bit = par_bit;
            next_receive_complete_flag = 1'b1;
            next_overrun = 1'b0;
        end else if (store) begin
            next_overrun = 1'b1;
        end else if (pop) begin
            next_receive_complete_flag = 1'b0;
        end
        // events set after the clear so a set wins
        if (store) begin
            next_irq_status.frame_done = 1'b1;
        end
        if (store && store_fe) begin
            next_irq_status.frame_error = 1'b1;
        end
        if (ev_noise) begin
            next_irq_status.noise_reject = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            entry <= rx_entry_s'(ENTRY_RESET);
            receive_complete_flag <= 1'b0;
            overrun <= 1'b0;
            irq_status <= irq_s'(IRQ_RESET);
            irq_out <= 1'b0;
        end else begin
            entry <= next_entry;
            receive_complete_flag <= next_receive_complete_flag;
            overrun <= next_overrun;
            irq_status <= next_irq_status;
            irq_out <= next_irq;
        end
    end
endmodule

// [verification/uart_rx_properties.sv]
`timescale 1ns/1ps
module uart_rx_properties
    import uart_rx_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // bus request
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    // bus answer and interrupt
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // request waiting for its answer
    sequence req_s;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    // single ack pulse
    sequence ack_s;
        wb_ack_out ##1 !wb_ack_out;
    endsequence
    logic rd;
    assign rd = wb_ack_out && !wb_we_in;
    // bus handshake
    ack_follows_a: assert property (req_s |=> ack_s)
        else $error("ack missing after request");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    reset_quiet_a: assert property ($rose(rstn_in) |->
        !wb_ack_out && !irq_out && wb_dat_out == 32'h0000_0000)
        else $error("outputs not quiet after reset");
    dat_hold_a: assert property (!wb_ack_out |-> $stable(wb_dat_out))
        else $error("read data moved without access");
    // read widths and unmapped places
    unmapped_zero_a: assert property (rd && wb_adr_in > REG_IRQ_MASK |->
        wb_dat_out == 32'h0000_0000) else $error("unmapped read not zero");
    ctrl_width_a: assert property (rd && wb_adr_in == REG_CTRL |->
        (wb_dat_out >> 5) == 32'h0000_0000) else $error("ctrl upper bits set");
    flag_width_a: assert property (rd && wb_adr_in == REG_STATUS |->
        (wb_dat_out >> 4) == 32'h0000_0000) else $error("status upper set");
    data_width_a: assert property (rd && wb_adr_in == REG_DATA |->
        (wb_dat_out >> 8) == 32'h0000_0000) else $error("data upper set");
    // masked interrupt stays low
    irq_masked_a: assert property (wb_ack_out && wb_we_in && wb_sel_in[0]
        && wb_adr_in == REG_IRQ_MASK && wb_dat_in[2:0] == 3'h0 |-> ##2 !irq_out)
        else $error("irq high with mask clear");
endmodule

// [verification/serial_sender.sv]
`timescale 1ns/1ps
module serial_sender (
    // clock
    input wire logic ref_clk_in,
    // serial line, idle high
    output logic line_out
);
    initial line_out = 1'b1;
    // one level for a number of clocks
    task automatic hold(input logic v, input int n);
        @(posedge ref_clk_in);
        line_out <= v;
        repeat (n - 1) @(posedge ref_clk_in);
    endtask
    // lsb first frame at exact receiver rate
    task automatic send(input logic [7:0] d, input int n, input logic pe,
            input logic p, input logic stop, input int bc, input int sc);
        hold(1'b0, bc);
        for (int i = 0; i < n; i++) begin
            hold(d[i], bc);
        end
        if (pe) begin
            hold(p, bc);
        end
        hold(stop, sc);
        hold(1'b1, 1);
    endtask
endmodule

// [verification/uart_async_rx_recovery_test.sv]
`timescale 1ns/1ps
module uart_async_rx_recovery_test;
    import uart_rx_pkg::*;
    logic ref_clk_in, rstn_in, cyc, stb, we, line, ack, irq, pe;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    int errors, compares, cycles, b, ds, bc;
    int exp_q[$];
    // design, far-end sender, clock
    uart_async_rx_recovery u_uart_async_rx_recovery (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .serial_receive_pin_in(line), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
    serial_sender u_serial_sender (.ref_clk_in(ref_clk_in), .line_out(line));
    initial begin
        ref_clk_in = 1'b0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    // hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            results;
        end
    end
    task automatic results;
        $display("summary: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic bus cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input int v);
        @(posedge ref_clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= 32'(v);
        sel <= 4'hf;
        do @(posedge ref_clk_in); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // rate, mode, length
    task automatic cfg(input int dl, input logic en);
        bus(1'b1, REG_BAUD, b);
        bus(1'b1, REG_CTRL, {27'h000_0000, dl[1:0], pe, ds[0], en});
        bc = (b + 1) * (ds ? 8 : 16);
        // idle line so a freshly enabled receiver sees high and arms
        repeat (bc) @(posedge ref_clk_in);
    endtask
    // random frame, expectation queued
    task automatic tx(input int n, input logic stop, input int sc);
        logic [7:0] v;
        logic p;
        v = 8'($urandom);
        p = 1'($urandom);
        exp_q.push_back({pe, p, ~stop, 8'(v & ((1 << n) - 1))});
        u_serial_sender.send(v, n, pe, p, stop, bc, sc);
    endtask
    // wait for a frame, compare, empty the buffer
    task automatic rx_check;
        int e;
        q = 32'h0000_0000;
        for (int k = 0; k < 500 && q[0] !== 1'b1; k++) begin
            bus(1'b0, REG_STATUS, 0);
        end
        chk("complete", 1, q[0]);
        e = exp_q.pop_front();
        chk("frame error", e[8], q[1]);
        if (e[10]) begin
            chk("parity", e[9], q[2]);
        end
        bus(1'b0, REG_DATA, 0);
        chk("data", e[7:0], q);
        bus(1'b0, REG_STATUS, 0);
        chk("emptied", 0, q[0]);
    endtask
    initial begin
        rstn_in = 1'b0;
        {cyc, stb, we, adr, sel, wdat} = '0;
        void'($urandom(32'hf514_ecb3));
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        // reset values, unmapped write ignored
        bus(1'b1, 8'h1c, 32'hffff_ffff);
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, 8'(a), 0);
            chk("reset read", 0, q);
        end
        $display("reset test done");
        // every speed and length
        for (ds = 0; ds < 2; ds++) begin
            for (int dl = 0; dl < 4; dl++) begin
                b = $urandom_range(3);
                pe = 1'($urandom);
                cfg(dl, 1'b1);
                tx(5 + dl, 1'b1, bc);
                rx_check;
            end
        end
        $display("mode test done");
        // low stop bit, interrupt raised and cleared
        ds = 0;
        pe = 1'b0;
        cfg(3, 1'b1);
        tx(8, 1'b0, bc);
        rx_check;
        bus(1'b0, REG_IRQ_STATUS, 0);
        chk("irq status", 3, q);
        chk("irq masked", 0, irq);
        bus(1'b1, REG_IRQ_MASK, 7);
        repeat (2) @(posedge ref_clk_in);
        chk("irq raised", 1, irq);
        bus(1'b1, REG_IRQ_STATUS, 7);
        repeat (2) @(posedge ref_clk_in);
        chk("irq cleared", 0, irq);
        $display("stop test done");
        // short glitch dropped, then a real frame
        u_serial_sender.hold(1'b0, 3 * (b + 1));
        u_serial_sender.hold(1'b1, 16 * (b + 1));
        bus(1'b0, REG_IRQ_STATUS, 0);
        chk("noise event", 4, q);
        bus(1'b0, REG_STATUS, 0);
        chk("no frame", 0, q[0]);
        bus(1'b1, REG_IRQ_STATUS, 7);
        tx(8, 1'b1, bc);
        rx_check;
        $display("noise test done");
        // next start right after the stop vote
        fork
            begin
                tx(8, 1'b1, 12 * (b + 1));
                tx(8, 1'b1, bc);
            end
        join_none
        rx_check;
        rx_check;
        wait fork;
        $display("early start test done");
        // two unread frames: second lost
        tx(8, 1'b1, bc);
        tx(8, 1'b1, bc);
        void'(exp_q.pop_back());
        bus(1'b0, REG_STATUS, 0);
        chk("overrun", 1, q[3]);
        rx_check;
        $display("overrun test done");
        // disable mid-frame flushes the receive buffer
        tx(8, 1'b1, bc);
        fork
            tx(8, 1'b1, bc);
        join_none
        repeat (4 * bc) @(posedge ref_clk_in);
        cfg(3, 1'b0);
        bus(1'b0, REG_STATUS, 0);
        chk("flushed", 0, q[0]);
        wait fork;
        exp_q.delete();
        cfg(3, 1'b1);
        tx(8, 1'b1, bc);
        rx_check;
        bus(1'b1, REG_IRQ_MASK, 0);
        repeat (2) @(posedge ref_clk_in);
        chk("irq off", 0, irq);
        $display("disable test done");
        results;
    end
endmodule
bind uart_async_rx_recovery uart_rx_properties u_uart_rx_properties (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .irq_out(irq_out));
